// file: dv/sf_flash_core_tb_top.sv
// Self-checking bench for the serial flash core
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, a, e); end end
module sf_flash_core_tb_top;
  // Short busy counts keep the run small
  localparam int PP = 300;
  localparam int SE = 5000;
  localparam int CE = 66000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wp_n = 1'b1;
  logic sclk;
  logic cs_n;
  logic si;
  logic hold_n;
  logic so;
  logic so_oe_n;
  logic write_in_progress;
  logic wel;
  logic [1:0] prot;
  logic stby;
  logic so_line;
  int failures = 0;
  int checks = 0;
  logic [7:0] rx [8];
  always #12.5ns clk = ~clk;
  // Data line has a pull-up while the flash is not driving
  assign so_line = so_oe_n ? 1'b1 : so;
  sf_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si),
    .o_hold_n(hold_n), .i_so(so_line));
  sf_flash_core #(.P_PP_CYC(PP), .P_SE_CYC(SE), .P_CE_CYC(CE)) dut_u (
    .i_core_clk(clk), .i_reset(rst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so),
    .o_so_oe_n(so_oe_n), .o_write_in_progress(write_in_progress),
    .o_write_enable_latch(wel), .o_protect_size_bits(prot),
    .o_standby(stby));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  // One framed command, optional 3 address bytes, nd counted data bytes
  task automatic frame(input logic [7:0] c, input logic use_a,
      input logic [15:0] a, input int nd, input logic [7:0] wd);
    logic [7:0] r;
    host_u.start();
    host_u.xfer(c, r);
    if (use_a) begin
      host_u.xfer(8'h00, r);
      host_u.xfer(a[15:8], r);
      host_u.xfer(a[7:0], r);
    end
    for (int i = 0; i < nd; i++) begin
      host_u.xfer(wd + 8'(i), r);
      rx[i] = r;
    end
    host_u.stop();
  endtask : frame
  task automatic wren();
    frame(sf_pkg::CMD_WREN, 1'b0, 16'h0, 0, 8'h00);
  endtask : wren
  task automatic rd(input logic [15:0] a, input int nd);
    frame(sf_pkg::CMD_READ, 1'b1, a, nd, 8'h00);
  endtask : rd
  // Waits out a self-timed operation and returns its busy length
  task automatic busy(output int n);
    int w;
    w = 0;
    n = 0;
    while (write_in_progress !== 1'b1 && w < 12) begin
      tick();
      w++;
    end
    `CHK(write_in_progress, 1'b1)
    `CHK(stby, 1'b0)
    while (write_in_progress === 1'b1 && n < 80000) begin
      tick();
      n++;
    end
    `CHK(wel, 1'b0)
    repeat (3) tick();
    `CHK(stby, 1'b1)
  endtask : busy
  task automatic t_reset();
    logic [7:0] r;
    `CHK(write_in_progress, 1'b0)
    `CHK(wel, 1'b0)
    `CHK(prot, sf_pkg::BP_RESET)
    `CHK(so_oe_n, 1'b1)
    `CHK(stby, 1'b1)
    host_u.xfer(sf_pkg::CMD_WREN, r);
    host_u.set_mode(1'b0);
    tick();
    `CHK(wel, 1'b0)
  endtask : t_reset
  task automatic t_ids();
    host_u.set_mode(1'b1);
    frame(sf_pkg::CMD_RDID, 1'b0, 16'h0, 3, 8'h00);
    `CHK(rx[0], sf_pkg::ID_MFR)
    `CHK(rx[1], sf_pkg::ID_DEV)
    `CHK(rx[2], sf_pkg::ID_DEV)
    frame(sf_pkg::CMD_SIG, 1'b0, 16'h0, 2, 8'h00);
    `CHK(rx[1], sf_pkg::ID_SIG)
    host_u.set_mode(1'b0);
  endtask : t_ids
  task automatic t_program();
    int n;
    wren();
    tick();
    `CHK(wel, 1'b1)
    frame(sf_pkg::CMD_CE, 1'b0, 16'h0, 0, 8'h00);
    busy(n);
    `CHK(n > CE - 200 && n <= CE + 2, 1'b1)
    // Pages are programmed only after the chip erase
    wren();
    frame(sf_pkg::CMD_PP, 1'b1, 16'h00fe, 3, 8'ha1);
    busy(n);
    `CHK(n > PP - 200 && n <= PP + 2, 1'b1)
    wren();
    frame(sf_pkg::CMD_PP, 1'b1, 16'h1000, 1, 8'h5c);
    busy(n);
    rd(16'hffff, 3);
    `CHK(rx[0], sf_pkg::ERASED)
    `CHK(rx[1], 8'ha3)
    rd(16'h00fe, 3);
    `CHK(rx[0], 8'ha1)
    `CHK(rx[1], 8'ha2)
    `CHK(rx[2], sf_pkg::ERASED)
  endtask : t_program
  task automatic t_sector();
    int n;
    wren();
    frame(sf_pkg::CMD_SE, 1'b1, 16'h0010, 0, 8'h00);
    frame(sf_pkg::CMD_RDSR, 1'b0, 16'h0, 1, 8'h00);
    `CHK(rx[0], 8'h03)
    busy(n);
    `CHK(n > SE - 200 && n <= SE + 2, 1'b1)
    frame(sf_pkg::CMD_RDSR, 1'b0, 16'h0, 1, 8'h00);
    `CHK(rx[0], 8'h00)
    rd(16'h0fff, 2);
    `CHK(rx[0], sf_pkg::ERASED)
    `CHK(rx[1], 8'h5c)
  endtask : t_sector
  task automatic t_protect();
    wren();
    frame(sf_pkg::CMD_WRSR, 1'b0, 16'h0, 1, 8'h04);
    tick();
    `CHK(prot, 2'h1)
    wren();
    frame(sf_pkg::CMD_PP, 1'b1, 16'hc000, 1, 8'h00);
    repeat (8) tick();
    `CHK(write_in_progress, 1'b0)
    rd(16'hc000, 1);
    `CHK(rx[0], sf_pkg::ERASED)
    @(posedge clk) wp_n <= 1'b0;
    wren();
    frame(sf_pkg::CMD_WRSR, 1'b0, 16'h0, 1, 8'h00);
    tick();
    `CHK(prot, 2'h1)
    `CHK(wel, 1'b0)
    @(posedge clk) wp_n <= 1'b1;
    wren();
    frame(sf_pkg::CMD_WRSR, 1'b0, 16'h0, 1, 8'h00);
    tick();
    `CHK(prot, 2'h0)
    frame(sf_pkg::CMD_PP, 1'b1, 16'h0200, 1, 8'h00);
    repeat (8) tick();
    `CHK(write_in_progress, 1'b0)
  endtask : t_protect
  // Hold between bytes must not advance the read stream
  task automatic t_hold();
    logic [7:0] r;
    host_u.start();
    host_u.xfer(sf_pkg::CMD_READ, r);
    host_u.xfer(8'h00, r);
    host_u.xfer(8'h0f, r);
    host_u.xfer(8'hff, r);
    host_u.xfer(8'h00, r);
    `CHK(r, sf_pkg::ERASED)
    host_u.hold_on();
    `CHK(so_oe_n, 1'b1)
    `CHK(stby, 1'b0)
    host_u.hold_off();
    host_u.xfer(8'h00, r);
    `CHK(r, 8'h5c)
    host_u.stop();
  endtask : t_hold
  task automatic end_of_test();
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) tick();
    t_reset();
    t_ids();
    t_program();
    t_sector();
    t_protect();
    t_hold();
    end_of_test();
  end
  // Watchdog sized above the sum of busy counts and frame traffic
  initial begin
    repeat (97000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule : sf_flash_core_tb_top

// file: dv/sf_host_model.sv
// Behavioural link host that drives the flash pins in mode 0 or mode 3
`timescale 1ns/1ps
module sf_host_model (
  // Link pins toward the flash
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  output logic o_hold_n,
  // Data line as seen on the board
  input wire logic i_so
);
  localparam time HALF = 100ns;
  logic mode3 = 1'b0;
  // Idle pins before the first frame
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end
  // Clock rests at the mode's idle level between frames
  task automatic set_mode(input logic m3);
    mode3 = m3;
    o_sclk = m3;
    #(HALF);
  endtask : set_mode
  task automatic start();
    o_cs_n = 1'b0;
    #(HALF);
  endtask : start
  // Sample late in the high phase so a slow output bit has settled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_si = tx[i];
      #(HALF);
      o_sclk = 1'b1;
      #(HALF);
      rx[i] = i_so;
    end
  endtask : xfer
  // Released data line carries no stale value
  task automatic stop();
    o_sclk = mode3;
    o_si = ~o_si;
    #(HALF);
    o_cs_n = 1'b1;
    #(HALF);
  endtask : stop
  // Clock keeps toggling during the pause; the flash must ignore it
  task automatic hold_on();
    o_hold_n = 1'b0;
    #(HALF);
    repeat (4) begin
      o_sclk = ~o_sclk;
      o_si = ~o_si;
      #(HALF);
    end
  endtask : hold_on
  task automatic hold_off();
    o_hold_n = 1'b1;
    #(HALF);
  endtask : hold_off
endmodule : sf_host_model

// file: inc/sf_pkg.sv
// Shared constants and types for the serial flash core
package sf_pkg;
  // Array geometry
  localparam int ADDR_W = 16;
  localparam int MEM_BYTES = 65536;
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 4096;
  // Command codes
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_WRSR = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_SE = 8'h20;
  localparam logic [7:0] CMD_CE = 8'hc7;
  localparam logic [7:0] CMD_RDID = 8'h9f;
  localparam logic [7:0] CMD_SIG = 8'hab;
  // Status register field positions
  localparam int ST_WIP = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam logic [1:0] BP_RESET = 2'h0;
  // Identity bytes, values are arbitrary
  localparam logic [7:0] ID_MFR = 8'h5a;
  localparam logic [7:0] ID_DEV = 8'h10;
  localparam logic [7:0] ID_SIG = 8'h05;
  localparam logic [7:0] ERASED = 8'hff;
  // Operation times in microseconds and core clock rate
  localparam int CLK_MHZ = 40;
  localparam int T_PP_TYP_US = 1400;
  localparam int T_PP_MAX_US = 5000;
  localparam int T_SE_TYP_US = 60000;
  localparam int T_SE_MAX_US = 120000;
  localparam int T_CE_TYP_US = 1000000;
  localparam int T_CE_MAX_US = 2000000;
  localparam int PP_CYC = T_PP_TYP_US * CLK_MHZ;
  localparam int SE_CYC = T_SE_TYP_US * CLK_MHZ;
  localparam int CE_CYC = T_CE_TYP_US * CLK_MHZ;
  // Pin bundle as sampled from the link
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } sf_pins_t;
  localparam sf_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0,
                                     hold_n: 1'b1, wp_n: 1'b1};
  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_IN, PH_OUT, PH_SKIP}
    sf_phase_t;
  typedef enum logic [2:0] {OP_NONE, OP_PP, OP_SE, OP_CE, OP_WRSR} sf_op_t;
endpackage : sf_pkg

// file: logic/sf_flash_core.sv
// Serial flash core: link decoder, status, protection and program engine
`timescale 1ns/1ps
module sf_flash_core #(
  parameter int P_PP_CYC = sf_pkg::PP_CYC,
  parameter int P_SE_CYC = sf_pkg::SE_CYC,
  parameter int P_CE_CYC = sf_pkg::CE_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Link pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic i_wp_n,
  output logic o_so,
  output logic o_so_oe_n,
  // Status
  output logic o_write_in_progress,
  output logic o_write_enable_latch,
  output logic [1:0] o_protect_size_bits,
  output logic o_standby
);
  sf_pkg::sf_pins_t pin_meta;
  sf_pkg::sf_pins_t pin_sync;
  logic sclk_prev;
  logic cs_prev;
  sf_pkg::sf_phase_t phase;
  sf_pkg::sf_op_t pend_op;
  sf_pkg::sf_op_t op;
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [1:0] addr_bytes;
  logic [7:0] out_byte;
  logic [7:0] pend_status;
  logic so_bit;
  logic drive;
  logic wel;
  logic [1:0] bp;
  logic [15:0] op_addr;
  logic [16:0] op_left;
  logic [31:0] op_timer;
  logic [7:0] mem [sf_pkg::MEM_BYTES];
  logic [7:0] pbuf [sf_pkg::PAGE_BYTES];
  logic [sf_pkg::PAGE_BYTES-1:0] pvalid;

  // Two flop synchronisers; the link clock is just another sampled input
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_meta <= sf_pkg::PINS_IDLE;
      pin_sync <= sf_pkg::PINS_IDLE;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      pin_meta <= '{sclk: i_sclk, cs_n: i_cs_n, si: i_si,
                    hold_n: i_hold_n, wp_n: i_wp_n};
      pin_sync <= pin_meta;
      sclk_prev <= pin_sync.sclk;
      cs_prev <= pin_sync.cs_n;
    end
  end

  // Edge detection; edges are dropped while deselected or held
  wire active = ~pin_sync.cs_n & pin_sync.hold_n;
  wire sclk_rise = active & pin_sync.sclk & ~sclk_prev;
  wire sclk_fall = active & ~pin_sync.sclk & sclk_prev;
  wire cs_rise = pin_sync.cs_n & ~cs_prev;
  wire [7:0] in_byte = {shift_in, pin_sync.si};
  wire byte_done = sclk_rise & (bit_cnt == 3'h7);
  wire write_in_progress = (op != sf_pkg::OP_NONE);

  // Command decode
  wire cmd_in_read = (in_byte == sf_pkg::CMD_READ);
  wire cmd_read = (cmd == sf_pkg::CMD_READ);
  wire cmd_pp = (cmd == sf_pkg::CMD_PP);
  wire cmd_se = (cmd == sf_pkg::CMD_SE);
  wire cmd_wrsr = (cmd == sf_pkg::CMD_WRSR);
  wire cmd_rdsr = (cmd == sf_pkg::CMD_RDSR);
  wire cmd_rdid = (cmd == sf_pkg::CMD_RDID);
  wire [23:0] addr_full = {addr[15:0], in_byte};
  wire addr_last = byte_done & (phase == sf_pkg::PH_ADDR) &
                   (addr_bytes == 2'h2);

  // Protected region grows from the top of the array
  wire addr_prot = (bp == 2'h3) | ((bp == 2'h2) & addr_full[15]) |
                   ((bp == 2'h1) & (addr_full[15:14] == 2'h3));
  wire write_ok = wel & ~addr_prot;

  // Status byte seen by the host
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[sf_pkg::ST_WIP] = write_in_progress;
    status[sf_pkg::ST_WEL] = wel;
    status[sf_pkg::ST_BP_HI:sf_pkg::ST_BP_LO] = bp;
  end

  // Pending operations start at deselect, only on a whole byte boundary
  wire frame_ok = cs_rise & (bit_cnt == 3'h0) & ~write_in_progress;
  wire start_wrsr = frame_ok & (pend_op == sf_pkg::OP_WRSR);
  wire start_op = frame_ok & (pend_op != sf_pkg::OP_NONE) &
                  (pend_op != sf_pkg::OP_WRSR);
  wire op_done = write_in_progress & (op_left == 17'h0) & (op_timer == 32'h0);

  // Link side transaction engine
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase <= sf_pkg::PH_CMD;
      pend_op <= sf_pkg::OP_NONE;
      bit_cnt <= 3'h0;
      shift_in <= 7'h00;
      cmd <= 8'h00;
      addr <= 24'h000000;
      addr_bytes <= 2'h0;
      out_byte <= 8'h00;
      pend_status <= 8'h00;
      so_bit <= 1'b0;
      drive <= 1'b0;
      wel <= 1'b0;
      bp <= sf_pkg::BP_RESET;
      pvalid <= '0;
    end else begin
      if (op_done | start_wrsr) begin
        wel <= 1'b0;
      end
      if (start_wrsr && pin_sync.wp_n) begin
        bp <= pend_status[sf_pkg::ST_BP_HI:sf_pkg::ST_BP_LO];
      end
      if (cs_rise) begin
        pend_op <= sf_pkg::OP_NONE;
      end
      // Deselect returns to the command phase
      if (pin_sync.cs_n) begin
        phase <= sf_pkg::PH_CMD;
        bit_cnt <= 3'h0;
        addr_bytes <= 2'h0;
        drive <= 1'b0;
      end
      if (sclk_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift_in <= {shift_in[5:0], pin_sync.si};
      end
      // Output changes on the falling edge, ready for the next rise
      if (sclk_fall) begin
        so_bit <= out_byte[3'h7 - bit_cnt];
        drive <= (phase == sf_pkg::PH_OUT);
      end
      if (byte_done) begin
        unique case (phase)
          sf_pkg::PH_CMD: begin
            cmd <= in_byte;
            phase <= sf_pkg::PH_SKIP;
            // Only status polling is served while busy
            if (write_in_progress && in_byte != sf_pkg::CMD_RDSR) begin
              phase <= sf_pkg::PH_SKIP;
            end else if (in_byte == sf_pkg::CMD_WREN) begin
              wel <= 1'b1;
            end else if (in_byte == sf_pkg::CMD_WRDI) begin
              wel <= 1'b0;
            end else if (in_byte == sf_pkg::CMD_RDSR) begin
              out_byte <= status;
              phase <= sf_pkg::PH_OUT;
            end else if (in_byte == sf_pkg::CMD_RDID) begin
              out_byte <= sf_pkg::ID_MFR;
              phase <= sf_pkg::PH_OUT;
            end else if (in_byte == sf_pkg::CMD_SIG) begin
              out_byte <= sf_pkg::ID_SIG;
              phase <= sf_pkg::PH_OUT;
            end else if (in_byte == sf_pkg::CMD_WRSR) begin
              phase <= sf_pkg::PH_IN;
            end else if (cmd_in_read || in_byte == sf_pkg::CMD_PP ||
                         in_byte == sf_pkg::CMD_SE) begin
              phase <= sf_pkg::PH_ADDR;
            end else if (in_byte == sf_pkg::CMD_CE) begin
              pend_op <= (wel && bp == 2'h0) ? sf_pkg::OP_CE :
                         sf_pkg::OP_NONE;
            end
          end
          sf_pkg::PH_ADDR: begin
            addr <= addr_full;
            addr_bytes <= addr_bytes + 2'h1;
            if (addr_bytes == 2'h2) begin
              phase <= sf_pkg::PH_SKIP;
              if (cmd_read) begin
                out_byte <= mem[addr_full[15:0]];
                phase <= sf_pkg::PH_OUT;
              end else if (cmd_pp) begin
                pvalid <= '0;
                phase <= sf_pkg::PH_IN;
                pend_op <= write_ok ? sf_pkg::OP_PP : sf_pkg::OP_NONE;
              end else if (cmd_se) begin
                pend_op <= write_ok ? sf_pkg::OP_SE : sf_pkg::OP_NONE;
              end
            end
          end
          sf_pkg::PH_IN: begin
            if (cmd_wrsr) begin
              pend_status <= in_byte;
              pend_op <= wel ? sf_pkg::OP_WRSR : sf_pkg::OP_NONE;
              phase <= sf_pkg::PH_SKIP;
            end else begin
              // Page data wraps inside the page
              pbuf[addr[7:0]] <= in_byte;
              pvalid[addr[7:0]] <= 1'b1;
              addr[7:0] <= addr[7:0] + 8'h01;
            end
          end
          sf_pkg::PH_OUT: begin
            if (cmd_read) begin
              addr[15:0] <= addr[15:0] + 16'h0001;
              out_byte <= mem[addr[15:0] + 16'h0001];
            end else if (cmd_rdsr) begin
              out_byte <= status;
            end else if (cmd_rdid) begin
              out_byte <= sf_pkg::ID_DEV;
            end
          end
          sf_pkg::PH_SKIP: begin
          end
        endcase
      end
    end
  end

  // Internal program and erase sequencer; busy ends when both the timer and the byte count reach zero
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      op <= sf_pkg::OP_NONE;
      op_addr <= 16'h0000;
      op_left <= 17'h00000;
      op_timer <= 32'h0;
    end else if (!write_in_progress) begin
      if (start_op) begin
        op <= pend_op;
        unique case (pend_op)
          sf_pkg::OP_PP: begin
            op_addr <= {addr[15:8], 8'h00};
            op_left <= 17'(sf_pkg::PAGE_BYTES);
            op_timer <= 32'(P_PP_CYC);
          end
          sf_pkg::OP_SE: begin
            op_addr <= {addr[15:12], 12'h000};
            op_left <= 17'(sf_pkg::SECTOR_BYTES);
            op_timer <= 32'(P_SE_CYC);
          end
          default: begin
            op_addr <= 16'h0000;
            op_left <= 17'(sf_pkg::MEM_BYTES);
            op_timer <= 32'(P_CE_CYC);
          end
        endcase
      end
    end else begin
      if (op_left != 17'h0) begin
        op_addr <= op_addr + 16'h0001;
        op_left <= op_left - 17'h00001;
      end
      if (op_timer != 32'h0) begin
        op_timer <= op_timer - 32'h1;
      end
      if (op_done) begin
        op <= sf_pkg::OP_NONE;
      end
    end
  end

  // Array write port; unloaded page bytes are skipped, not erased
  wire mem_we = write_in_progress & (op_left != 17'h0) &
                ((op != sf_pkg::OP_PP) | pvalid[op_addr[7:0]]);
  wire [7:0] mem_wdata = (op == sf_pkg::OP_PP) ? pbuf[op_addr[7:0]] :
                         sf_pkg::ERASED;
  always_ff @(posedge i_core_clk) begin
    if (mem_we) begin
      mem[op_addr] <= mem_wdata;
    end
  end

  // Outputs
  assign o_so = so_bit;
  assign o_so_oe_n = ~(drive & active);
  assign o_write_in_progress = write_in_progress;
  assign o_write_enable_latch = wel;
  assign o_protect_size_bits = bp;
  assign o_standby = pin_sync.cs_n & ~write_in_progress;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  AST_OE_SELECTED: assert property (
    !o_so_oe_n |-> !pin_sync.cs_n) else $error("output driven deselected");
  AST_HOLD_RELEASE: assert property (
    !pin_sync.hold_n |-> o_so_oe_n && $stable(bit_cnt))
    else $error("activity during hold");
  AST_STANDBY: assert property (
    o_standby |-> pin_sync.cs_n && !o_write_in_progress)
    else $error("standby while busy or selected");
  AST_BUSY_START: assert property (
    start_op |=> o_write_in_progress [*2])
    else $error("busy not raised");
  AST_WEL_CLEAR: assert property (
    op_done |=> !o_write_enable_latch && !o_write_in_progress)
    else $error("latch not cleared after operation");
  AST_WP_LOCK: assert property (
    !pin_sync.wp_n |=> $stable(o_protect_size_bits))
    else $error("protect bits changed under write protect");
  AST_PROTECT: assert property (
    addr_last && (cmd_se || cmd_pp) && addr_prot
    |=> pend_op == sf_pkg::OP_NONE) else $error("protected write accepted");
  AST_READ_SEQ: assert property (
    byte_done && phase == sf_pkg::PH_OUT && cmd_read
    |=> addr[15:0] == $past(addr[15:0]) + 16'h0001)
    else $error("read address not advanced");
endmodule : sf_flash_core
